// File: bench/brw_bank_props.sv
/*
  Checker for brw_bank: concurrent assertions on the top module's ports.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module brw_bank_props #(
  parameter int AW = 8
) (
  // Clock, reset and bus
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          cyc_i,
  input wire logic          stb_i,
  input wire logic          we_i,
  input wire logic [AW-1:0] adr_i,
  input wire logic [31:0]   dat_o,
  input wire logic          ack_o,
  // Events and lookups
  input wire logic          cpl_abort_sent_i,
  input wire logic          cpl_ca_rcvd_i,
  input wire logic          cpl_ur_rcvd_i,
  input wire logic          io_req_i,
  input wire logic          io_fwd_o,
  input wire logic          mem_req_i,
  input wire logic          mem_fwd_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Shadow of the sticky abort flags; only reset clears them
  logic [2:0] seen_reg;
  logic [2:0] seen_next;
  always_comb seen_next = seen_reg | {cpl_ur_rcvd_i, cpl_ca_rcvd_i, cpl_abort_sent_i};
  always_ff @(posedge clk_i) begin
    if (rst_i) seen_reg <= 3'h0;
    else seen_reg <= seen_next;
  end

  ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack not a pulse");
  lat_zero_a: assert property (ack_o && $past(adr_i) == brw_pkg::OFF_BUS_LAT
    |-> dat_o[31:24] == 8'h00) else $error("latency byte not zero");
  io_ind_a: assert property (ack_o && !$past(we_i) && $past(adr_i) == brw_pkg::OFF_IO_STAT
    |-> dat_o[3:0] == 4'h1 && dat_o[11:8] == 4'h1) else $error("indicator wrong");
  st_zero_a: assert property (ack_o && $past(adr_i) == brw_pkg::OFF_IO_STAT
    |-> {dat_o[26:25], dat_o[23], dat_o[21]} == 4'h0) else $error("status zero bits set");
  mem_rsvd_a: assert property (ack_o && $past(adr_i) == brw_pkg::OFF_MEM_WIN
    |-> dat_o[3:0] == 4'h0 && dat_o[19:16] == 4'h0) else $error("memory reserved set");
  abort_sticky_a: assert property (ack_o && !$past(we_i)
    && $past(adr_i) == 8'h1c |-> (dat_o[29:27] & $past(seen_reg)) == $past(seen_reg))
    else $error("abort flag lost");
  io_fwd_gate_a: assert property (io_fwd_o |-> $past(io_req_i))
    else $error("io forward without request");
  mem_fwd_gate_a: assert property (mem_fwd_o |-> $past(mem_req_i))
    else $error("memory forward without request");
endmodule : brw_bank_props

bind brw_bank brw_bank_props #(.AW(AW)) u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .cpl_abort_sent_i(cpl_abort_sent_i), .cpl_ca_rcvd_i(cpl_ca_rcvd_i),
  .cpl_ur_rcvd_i(cpl_ur_rcvd_i), .io_req_i(io_req_i), .io_fwd_o(io_fwd_o),
  .mem_req_i(mem_req_i), .mem_fwd_o(mem_fwd_o));

// File: bench/brw_bank_tb.sv
/*
  Self-checking bench for brw_bank: register map, status events and
  window lookups, with register accesses through the requester model.
  Assumes the checker is bound in separately.
*/
`timescale 1ns/1ns
module brw_bank_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, par_en = 1'b0, serr_en = 1'b0;
  logic        io_req = 1'b0, mem_req = 1'b0, io_fwd, io_v, mem_fwd, mem_v;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [5:0]  ev = 6'h00;
  logic [31:0] dat_w, dat_r, q, io_addr = 32'h0, mem_addr = 32'h0;
  int          failures = 0;
  int          n_checks = 0;

  // Design and requester facing each other on the bus
  brw_bank u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
    .par_resp_en_i(par_en), .serr_en_i(serr_en), .par_err_i(ev[0]),
    .cpl_abort_sent_i(ev[1]), .cpl_ca_rcvd_i(ev[2]), .cpl_ur_rcvd_i(ev[3]),
    .err_msg_sent_i(ev[4]), .poison_rcvd_i(ev[5]), .io_req_i(io_req),
    .io_addr_i(io_addr), .mem_req_i(mem_req), .mem_addr_i(mem_addr),
    .io_fwd_o(io_fwd), .io_fwd_valid_o(io_v), .mem_fwd_o(mem_fwd), .mem_fwd_valid_o(mem_v));
  brw_requester u_req (.clk_i(clk_i), .ack_i(ack), .dat_i(dat_r), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dat_w));

  // 100 MHz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task results;
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    u_req.access(1'b1, a, s, d, q);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
    u_req.access(1'b0, a, 4'hf, 32'h0, q);
    chk(q, e);
  endtask : rd

  task pulse(input logic [5:0] v);
    @(posedge clk_i) ev <= v;
    @(posedge clk_i) ev <= 6'h00;
  endtask : pulse

  // Reset values, then a second reset in mid-run must restore them
  task t_reset(input logic again);
    if (again) begin
      @(posedge clk_i) rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
    end
    rd(8'h18, 32'h0);
    rd(8'h1c, 32'h0000_0101);
    rd(8'h20, 32'h0);
    rd(8'h30, 32'h0);
  endtask : t_reset

  // Status events: gated sets, sticky read-only flags, write-one-to-clear
  task t_events;
    pulse(6'h3f);
    rd(8'h1c, 32'hb800_0101);
    wr(8'h1c, 4'h8, 32'hff00_0000);
    rd(8'h1c, 32'h3800_0101);
    par_en <= 1'b1;
    serr_en <= 1'b1;
    pulse(6'h11);
    rd(8'h1c, 32'h7900_0101);
    wr(8'h1c, 4'h8, 32'h0000_0000);
    rd(8'h1c, 32'h7900_0101);
    wr(8'h1c, 4'h8, 32'h4100_0000);
    rd(8'h1c, 32'h3800_0101);
    // Poisoned TLP in the very cycle of its clear: the set must win
    fork
      wr(8'h1c, 4'h8, 32'h8000_0000);
      pulse(6'h20);
    join
    rd(8'h1c, 32'hb800_0101);
    wr(8'h1c, 4'h8, 32'h8000_0000);
    rd(8'h1c, 32'h3800_0101);
  endtask : t_events

  // Write all ones: only the writable fields keep them
  task t_write;
    wr(8'h18, 4'hf, 32'hffff_ffff);
    rd(8'h18, 32'h0000_0000);
    wr(8'h1c, 4'h3, 32'hffff_ffff);
    rd(8'h1c, 32'h3800_f1f1);
    // Ones into the hardwired and reserved status bits, zeros into the sticky ones
    wr(8'h1c, 4'hc, 32'h06ff_0000);
    rd(8'h1c, 32'h3800_f1f1);
    wr(8'h20, 4'hf, 32'hffff_ffff);
    rd(8'h20, 32'hfff0_fff0);
    wr(8'h40, 4'hf, 32'hffff_ffff);
    rd(8'h40, 32'h0);
  endtask : t_write

  // Window edges: one below, bottom, top, one above, then wrong upper half for I/O and a mid-window address for memory
  task t_window;
    logic [31:0] ia [5];
    logic [31:0] ma [5];
    logic [4:0]  ie;
    logic [4:0]  me;
    ia = '{32'h0001_1fff, 32'h0001_2000, 32'h0001_3fff, 32'h0001_4000, 32'h0000_2000};
    ma = '{32'h001f_ffff, 32'h0020_0000, 32'h003f_ffff, 32'h0040_0000, 32'h0030_0000};
    ie = 5'h06;
    me = 5'h16;
    wr(8'h1c, 4'h3, 32'h0000_3020);
    wr(8'h30, 4'hf, 32'h0001_0001);
    wr(8'h20, 4'hf, 32'h0030_0020);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i);
      {io_req, mem_req, io_addr, mem_addr} <= {2'h3, ia[i], ma[i]};
      @(posedge clk_i);
      {io_req, mem_req} <= 2'h0;
      #1 chk(32'({io_v, io_fwd, mem_v, mem_fwd}),
             32'({1'b1, ie[i], 1'b1, me[i]}));
    end
  endtask : t_window

  // Main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset(1'b0);
    t_events();
    t_write();
    t_window();
    t_reset(1'b1);
    results();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    results();
  end
endmodule : brw_bank_tb

// File: bench/brw_requester.sv
/*
  Configuration requester model: a classic Wishbone master that issues
  single reads and writes when the bench asks for them.
  Assumes the slave answers with ack on clk_i; the bench owns the timeout.
*/
`timescale 1ns/1ns
module brw_requester (
  // Clock and slave answer
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  // Master request
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  // Idle bus from time zero
  initial begin
    {cyc_o, stb_o, we_o} = 3'h0;
    {adr_o, sel_o, dat_o} = 44'h0;
  end

  // One single cycle, held whole until ack is sampled at a rising edge
  task access(input logic w, input logic [7:0] a, input logic [3:0] s,
              input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o} <= {2'h3, w};
    {adr_o, sel_o, dat_o} <= {a, s, d}; // Lanes sent whole as selected
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    {cyc_o, stb_o} <= 2'h0;
    // Released address and data lines show the inverse so the slave cannot lean on stale values
    {adr_o, dat_o} <= {~a, ~d};
  endtask : access
endmodule : brw_requester

// File: src/brw_bank.sv
/*
  Bridge window and secondary status register bank with a classic Wishbone
  slave, event inputs for the secondary-side status flags and I/O and memory
  forwarding decisions. Assumes event and enable inputs come from logic on
  clk_i, each event a one-cycle pulse.
*/
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ns
// What this block does
// R1 - Secondary latency timer byte always reads zero.
// R2 - I/O base and limit indicator nibbles read one for 32-bit I/O.
// R3 - I/O base bits 7:4 store window bottom bits 15:12, low bits zero.
// R4 - I/O limit bits 15:12 store window top bits 15:12, low bits ones.
// R5 - I/O transactions forward when the address falls in the I/O window.
// R6 - I/O window bits 31:16 come from the separate upper registers.
// R7 - Secondary status bits 21, 23 and 26:25 read zero.
// R8 - Bit 24 sets on parity error only when response enabled; write one clears.
// R9 - Bit 27 sets when a request completes with Completer Abort.
// R10 - Bit 28 sets on received Completion with Completer Abort.
// R11 - Bit 29 sets on received Completion with Unsupported Request.
// R12 - Bit 30 sets on fatal or nonfatal message with system error enabled.
// R13 - Bit 31 sets on received poisoned TLP; write one clears.
// R14 - Memory base bits 15:4 store window bottom bits 31:20, low zero.
// R15 - Memory limit gives top bits 31:20, low ones; both decide forwarding.
// R16 - Write one clears, write zero keeps; reserved bits keep their value. Here bits 27-29 ignore bus writes.
module brw_bank #(
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  // Enables from the bridge control side
  input  wire logic          par_resp_en_i,
  input  wire logic          serr_en_i,
  // Secondary-side event pulses
  input  wire logic          par_err_i,
  input  wire logic          cpl_abort_sent_i,
  input  wire logic          cpl_ca_rcvd_i,
  input  wire logic          cpl_ur_rcvd_i,
  input  wire logic          err_msg_sent_i,
  input  wire logic          poison_rcvd_i,
  // Forwarding lookups
  input  wire logic          io_req_i,
  input  wire logic [31:0]   io_addr_i,
  input  wire logic          mem_req_i,
  input  wire logic [31:0]   mem_addr_i,
  output logic               io_fwd_o,
  output logic               io_fwd_valid_o,
  output logic               mem_fwd_o,
  output logic               mem_fwd_valid_o
);

  // Register state
  logic [3:0]  io_base_reg,   io_base_next;
  logic [3:0]  io_limit_reg,  io_limit_next;
  logic [15:0] io_ubase_reg,  io_ubase_next;
  logic [15:0] io_ulimit_reg, io_ulimit_next;
  logic [11:0] mem_base_reg,  mem_base_next;
  logic [11:0] mem_limit_reg, mem_limit_next;
  logic        par_err_reg,   par_err_next;
  logic        sig_tabt_reg,  sig_tabt_next;
  logic        rcv_tabt_reg,  rcv_tabt_next;
  logic        rcv_mabt_reg,  rcv_mabt_next;
  logic        sys_err_reg,   sys_err_next;
  logic        det_perr_reg,  det_perr_next;

  // Bus state
  logic        ack_reg,       ack_next;
  logic [31:0] rdat_reg,      rdat_next;

  // Forwarding state
  logic        io_fwd_reg,    io_fwd_next;
  logic        io_vld_reg,    io_vld_next;
  logic        mem_fwd_reg,   mem_fwd_next;
  logic        mem_vld_reg,   mem_vld_next;

  // Decode and helpers
  logic        bus_req;
  logic        wr_strobe;
  logic [7:0]  byte_adr;
  logic [31:0] rd_word;
  logic [31:0] io_lo_bound;
  logic [31:0] io_hi_bound;
  logic [31:0] mem_lo_bound;
  logic [31:0] mem_hi_bound;
  logic        io_hit;
  logic        mem_hit;

  // One access per request: ack is held off while a previous ack is still high
  always_comb begin
    bus_req   = cyc_i && stb_i && !ack_reg;
    wr_strobe = bus_req && we_i;
    byte_adr  = 8'(adr_i);
  end

  // Window bounds: upper I/O bits from the upper registers, implied low bits
  always_comb begin
    io_lo_bound  = {io_ubase_reg, io_base_reg, brw_pkg::IO_BASE_LOW};    // [R3] [R6]
    io_hi_bound  = {io_ulimit_reg, io_limit_reg, brw_pkg::IO_LIMIT_LOW}; // [R4] [R6]
    mem_lo_bound = {mem_base_reg, brw_pkg::MEM_BASE_LOW};                // [R14]
    mem_hi_bound = {mem_limit_reg, brw_pkg::MEM_LIMIT_LOW};              // [R15]
  end

  brw_win_match #(
    .W (32)
  ) u_io_match (
    .addr_i  (io_addr_i),
    .base_i  (io_lo_bound),
    .limit_i (io_hi_bound),
    .hit_o   (io_hit)
  );

  brw_win_match #(
    .W (32)
  ) u_mem_match (
    .addr_i  (mem_addr_i),
    .base_i  (mem_lo_bound),
    .limit_i (mem_hi_bound),
    .hit_o   (mem_hit)
  );

  // Read mux; reserved bits read zero, hardwired bits read their fixed values, unmapped words read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (byte_adr)
      brw_pkg::OFF_BUS_LAT: begin
        rd_word[brw_pkg::SEC_LAT_LO +: 8] = brw_pkg::SEC_LAT_VALUE;    // [R1]
      end
      brw_pkg::OFF_IO_STAT: begin
        rd_word[brw_pkg::IO_IND_LO +: 4]   = brw_pkg::IO_32BIT_IND;    // [R2]
        rd_word[brw_pkg::IO_LIM_IND +: 4]  = brw_pkg::IO_32BIT_IND;    // [R2]
        rd_word[brw_pkg::IO_BASE_LO +: 4]  = io_base_reg;
        rd_word[brw_pkg::IO_LIMIT_LO +: 4] = io_limit_reg;
        // Bits 23:16 and 26:25 stay zero, none of them has meaning here [R7]
        rd_word[brw_pkg::ST_PAR_ERR]  = par_err_reg;
        rd_word[brw_pkg::ST_SIG_TABT] = sig_tabt_reg;
        rd_word[brw_pkg::ST_RCV_TABT] = rcv_tabt_reg;
        rd_word[brw_pkg::ST_RCV_MABT] = rcv_mabt_reg;
        rd_word[brw_pkg::ST_SYS_ERR]  = sys_err_reg;
        rd_word[brw_pkg::ST_DET_PERR] = det_perr_reg;
      end
      brw_pkg::OFF_MEM_WIN: begin
        rd_word[brw_pkg::MEM_BASE_LO +: 12]  = mem_base_reg;
        rd_word[brw_pkg::MEM_LIMIT_LO +: 12] = mem_limit_reg;
      end
      brw_pkg::OFF_IO_UPPER: begin
        rd_word = {io_ulimit_reg, io_ubase_reg};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Bus answer: ack one cycle after the request, dropped the cycle after
  always_comb begin
    ack_next  = bus_req;
    rdat_next = bus_req ? rd_word : 32'h0000_0000;
  end

  // Writable fields, honouring byte selects; reserved bits simply have no storage
  always_comb begin
    io_base_next   = io_base_reg;
    io_limit_next  = io_limit_reg;
    io_ubase_next  = io_ubase_reg;
    io_ulimit_next = io_ulimit_reg;
    mem_base_next  = mem_base_reg;
    mem_limit_next = mem_limit_reg;
    if (wr_strobe && byte_adr == brw_pkg::OFF_IO_STAT) begin
      if (sel_i[0]) begin
        io_base_next = dat_i[brw_pkg::IO_BASE_LO +: 4];              // [R3]
      end
      if (sel_i[1]) begin
        io_limit_next = dat_i[brw_pkg::IO_LIMIT_LO +: 4];            // [R4]
      end
    end
    if (wr_strobe && byte_adr == brw_pkg::OFF_MEM_WIN) begin
      if (sel_i[0]) begin
        mem_base_next[3:0] = dat_i[7:4];                             // [R14]
      end
      if (sel_i[1]) begin
        mem_base_next[11:4] = dat_i[15:8];                           // [R14]
      end
      if (sel_i[2]) begin
        mem_limit_next[3:0] = dat_i[23:20];                          // [R15] [R16]
      end
      if (sel_i[3]) begin
        mem_limit_next[11:4] = dat_i[31:24];                         // [R15]
      end
    end
    if (wr_strobe && byte_adr == brw_pkg::OFF_IO_UPPER) begin
      if (sel_i[0]) begin
        io_ubase_next[7:0] = dat_i[7:0];                             // [R6]
      end
      if (sel_i[1]) begin
        io_ubase_next[15:8] = dat_i[15:8];                           // [R6]
      end
      if (sel_i[2]) begin
        io_ulimit_next[7:0] = dat_i[23:16];                          // [R6]
      end
      if (sel_i[3]) begin
        io_ulimit_next[15:8] = dat_i[31:24];                         // [R6]
      end
    end
  end

  // Status flags; a hardware set in the clearing cycle wins over the clear
  always_comb begin
    logic clr_en;
    clr_en = wr_strobe && byte_adr == brw_pkg::OFF_IO_STAT && sel_i[3];
    par_err_next  = par_err_reg;
    sys_err_next  = sys_err_reg;
    det_perr_next = det_perr_reg;
    if (clr_en && dat_i[brw_pkg::ST_PAR_ERR]) begin
      par_err_next = 1'b0;                                           // [R16]
    end
    if (clr_en && dat_i[brw_pkg::ST_SYS_ERR]) begin
      sys_err_next = 1'b0;                                           // [R16]
    end
    if (clr_en && dat_i[brw_pkg::ST_DET_PERR]) begin
      det_perr_next = 1'b0;                                          // [R16]
    end
    if (par_err_i && par_resp_en_i) begin
      par_err_next = 1'b1;                                           // [R8]
    end
    if (err_msg_sent_i && serr_en_i) begin
      sys_err_next = 1'b1;                                           // [R12]
    end
    if (poison_rcvd_i) begin
      det_perr_next = 1'b1;                                          // [R13]
    end
    // Read-only flags: only reset clears them, bus writes leave them alone
    sig_tabt_next = sig_tabt_reg || cpl_abort_sent_i;                // [R9]
    rcv_tabt_next = rcv_tabt_reg || cpl_ca_rcvd_i;                   // [R10]
    rcv_mabt_next = rcv_mabt_reg || cpl_ur_rcvd_i;                   // [R11]
  end

  // Forwarding decision, registered so answers appear one cycle after a lookup
  always_comb begin
    io_vld_next  = io_req_i;
    io_fwd_next  = io_req_i && io_hit;                               // [R5]
    mem_vld_next = mem_req_i;
    mem_fwd_next = mem_req_i && mem_hit;                             // [R15]
  end

  // State registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_base_reg   <= brw_pkg::IO_NIB_RST;
      io_limit_reg  <= brw_pkg::IO_NIB_RST;
      io_ubase_reg  <= brw_pkg::IO_UPPER_RST;
      io_ulimit_reg <= brw_pkg::IO_UPPER_RST;
      mem_base_reg  <= brw_pkg::MEM_FIELD_RST;
      mem_limit_reg <= brw_pkg::MEM_FIELD_RST;
      par_err_reg   <= 1'b0;
      sig_tabt_reg  <= 1'b0;
      rcv_tabt_reg  <= 1'b0;
      rcv_mabt_reg  <= 1'b0;
      sys_err_reg   <= 1'b0;
      det_perr_reg  <= 1'b0;
      ack_reg       <= 1'b0;
      rdat_reg      <= 32'h0000_0000;
      io_fwd_reg    <= 1'b0;
      io_vld_reg    <= 1'b0;
      mem_fwd_reg   <= 1'b0;
      mem_vld_reg   <= 1'b0;
    end else begin
      io_base_reg   <= io_base_next;
      io_limit_reg  <= io_limit_next;
      io_ubase_reg  <= io_ubase_next;
      io_ulimit_reg <= io_ulimit_next;
      mem_base_reg  <= mem_base_next;
      mem_limit_reg <= mem_limit_next;
      par_err_reg   <= par_err_next;
      sig_tabt_reg  <= sig_tabt_next;
      rcv_tabt_reg  <= rcv_tabt_next;
      rcv_mabt_reg  <= rcv_mabt_next;
      sys_err_reg   <= sys_err_next;
      det_perr_reg  <= det_perr_next;
      ack_reg       <= ack_next;
      rdat_reg      <= rdat_next;
      io_fwd_reg    <= io_fwd_next;
      io_vld_reg    <= io_vld_next;
      mem_fwd_reg   <= mem_fwd_next;
      mem_vld_reg   <= mem_vld_next;
    end
  end

  // Outputs straight from flops
  assign dat_o           = rdat_reg;
  assign ack_o           = ack_reg;
  assign io_fwd_o        = io_fwd_reg;
  assign io_fwd_valid_o  = io_vld_reg;
  assign mem_fwd_o       = mem_fwd_reg;
  assign mem_fwd_valid_o = mem_vld_reg;

endmodule : brw_bank

// File: src/brw_pkg.sv
/*
  Constants for the bridge window and secondary status register bank:
  word offsets, field positions, hardwired values and reset values.
  Assumes a byte-addressed Wishbone bus with 32-bit data words.
*/
package brw_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_BUS_LAT   = 8'h18;
  localparam logic [7:0] OFF_IO_STAT   = 8'h1c;
  localparam logic [7:0] OFF_MEM_WIN   = 8'h20;
  localparam logic [7:0] OFF_IO_UPPER  = 8'h30;

  // Hardwired values
  localparam logic [7:0] SEC_LAT_VALUE = 8'h00;
  localparam logic [3:0] IO_32BIT_IND  = 4'h1;

  // Reset values of the writable fields
  localparam logic [3:0]  IO_NIB_RST    = 4'h0;
  localparam logic [11:0] MEM_FIELD_RST = 12'h000;
  localparam logic [15:0] IO_UPPER_RST  = 16'h0000;

  // Implied low address bits of the windows
  localparam logic [11:0] IO_BASE_LOW   = 12'h000;
  localparam logic [11:0] IO_LIMIT_LOW  = 12'hfff;
  localparam logic [19:0] MEM_BASE_LOW  = 20'h00000;
  localparam logic [19:0] MEM_LIMIT_LOW = 20'hfffff;

  // Field positions inside the 0x1c word
  localparam int IO_IND_LO    = 0;
  localparam int IO_BASE_LO   = 4;
  localparam int IO_LIM_IND   = 8;
  localparam int IO_LIMIT_LO  = 12;
  localparam int ST_PAR_ERR   = 24;
  localparam int ST_SIG_TABT  = 27;
  localparam int ST_RCV_TABT  = 28;
  localparam int ST_RCV_MABT  = 29;
  localparam int ST_SYS_ERR   = 30;
  localparam int ST_DET_PERR  = 31;

  // Field positions inside the 0x20 and 0x18 words
  localparam int MEM_BASE_LO  = 4;
  localparam int MEM_LIMIT_LO = 20;
  localparam int SEC_LAT_LO   = 24;

endpackage : brw_pkg

// File: src/brw_win_match.sv
/*
  Address window comparator: reports whether an address lies inside the
  inclusive range from base to limit. Purely combinational; the caller
  registers the result.
*/
`timescale 1ns/1ns
module brw_win_match #(
  parameter int W = 32
) (
  // Address under test and window bounds
  input  wire logic [W-1:0] addr_i,
  input  wire logic [W-1:0] base_i,
  input  wire logic [W-1:0] limit_i,
  // Result
  output logic              hit_o
);

  // A base above the limit closes the window, so nothing matches
  always_comb begin
    hit_o = (addr_i >= base_i) && (addr_i <= limit_i);
  end

endmodule : brw_win_match
